/* File: core/lee_defs.svh */
// Register map, field positions, reset values and numeric limits of the luma edge enhancer
`ifndef LEE_DEFS_SVH
`define LEE_DEFS_SVH
// ----------------------------------------
// Register byte offsets and the address bit that selects the coefficient banks
// ----------------------------------------
`define LEE_A_CTRL     12'h000
`define LEE_A_CORE     12'h004
`define LEE_A_SLOPE    12'h008
`define LEE_A_GAIN     12'h00C
`define LEE_A_OUTSZ    12'h010
`define LEE_A_INSZ     12'h014
`define LEE_A_RSZ      12'h018
`define LEE_A_PHASE    12'h01C
`define LEE_A_STAT     12'h020
`define LEE_A_LINE     12'h024
`define LEE_COEF_BIT   8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LEE_F_EN       0
`define LEE_F_FIVE     1
`define LEE_F_V7       2
`define LEE_F_VLO      16
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LEE_R_CORE     8'h00
`define LEE_R_SLOPE    4'h1
`define LEE_R_GAIN     8'h10
`define LEE_R_SIZE     12'h000
`define LEE_R_RSZ      11'h100
// ----------------------------------------
// Limits and arithmetic constants
// ----------------------------------------
`define LEE_MAXW_V4    12'h500
`define LEE_MAXW_V7    12'h280
`define LEE_RSZ_MIN    11'h040
`define LEE_RSZ_MAX    11'h400
`define LEE_RSZ_4PH    11'h200
`define LEE_HPF_MAX    9'sh0FF
`define LEE_HPF_MIN    9'sh100
`define LEE_TRIM       12'h004
`define LEE_FIRST_IDX  12'h004
`define LEE_ROUND      17'sh00008
`define LEE_SHIFT      4
`define LEE_Y_MAX      8'hFF
`define LEE_SZ4_MUL    32'h20
`define LEE_SZ4_RND    32'h10
`define LEE_SZ7_MUL    32'h40
`define LEE_SZ7_RND    32'h20
`define LEE_SZ_FRAC    8
`define LEE_SZ_ADD7    12'h007
`define LEE_SZ_ADD4    12'h004
`endif

/* File: core/lee_pkg.sv */
// Types shared by the luma edge enhancer
package lee_pkg;
	// One stream sample: luma, its chroma, line start and line end
	typedef struct packed {
		logic [7:0] luma;
		logic [7:0] chroma;
		logic       sol;
		logic       eol;
	} lee_pix_t;
	// Software control word
	typedef struct packed {
		logic v7;
		logic five;
		logic en;
	} lee_ctrl_t;
endpackage

/* File: core/lee_enhance.sv */
// Luma edge enhancer with trimming, sizing checks, coefficient banks and AXI4-Lite registers
`timescale 1ns/1ps
`include "lee_defs.svh"
module lee_enhance #(
	parameter int COEF_N = 32,
	parameter int AW     = 12
) (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// AXI4-Lite write address and data
	input  wire logic [AW-1:0]   s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	// AXI4-Lite read
	input  wire logic [AW-1:0]   s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Horizontally resized samples in
	input  wire logic            in_valid,
	input  wire lee_pkg::lee_pix_t in_pix,
	// Samples toward the line memories
	output logic                 out_valid,
	output lee_pkg::lee_pix_t    out_pix
);
	import lee_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Bank indexing below assumes 32 entries and a map that fits the address
	if (COEF_N != 32 || AW < 12) begin : g_chk
		$error("lee_enhance: COEF_N must be 32 and AW at least 12");
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	lee_ctrl_t   ctrl_q;                  // Enable, kernel select, seven-tap sizing mode
	logic [7:0]  core_q;                  // Coring threshold
	logic [3:0]  gain_slope_q;            // Slope of gain curve
	logic [7:0]  gain_q;                  // Gain ceiling
	logic [11:0] ow_q, oh_q;              // Final output size
	logic [11:0] iw_q, ih_q;              // Programmed input size
	logic [10:0] hrsz_q, vrsz_q;          // Resize factors
	logic [2:0]  sph_q, spv_q;            // Starting phases
	logic [9:0]  coef_q [2][COEF_N];      // Coefficient banks, [0] horizontal
	logic [5:0]  stat_q;                  // Live status word
	logic [11:0] line_len_q;              // Length of last input line
	logic        hang_q;                  // Sticky size fault

	// Sizing equation shared by both directions
	function automatic logic [11:0] lee_size(input logic seven, input logic vert,
		input logic [2:0] sp, input logic [11:0] o, input logic [10:0] f);
		logic [31:0] acc;
		if (seven)
			acc = `LEE_SZ7_MUL * 32'(sp) + (32'(o) - 32'h1) * 32'(f) + `LEE_SZ7_RND;
		else
			acc = `LEE_SZ4_MUL * 32'(sp) + (32'(o) - 32'h1) * 32'(f) + `LEE_SZ4_RND;
		lee_size = 12'(acc >> `LEE_SZ_FRAC) + ((vert && !seven) ? `LEE_SZ_ADD4 : `LEE_SZ_ADD7);
	endfunction

	// Clamp a written factor into the legal span
	function automatic logic [10:0] lee_rsz(input logic [10:0] v);
		lee_rsz = (v < `LEE_RSZ_MIN) ? `LEE_RSZ_MIN : (v > `LEE_RSZ_MAX) ? `LEE_RSZ_MAX : v;
	endfunction

	// Register read view; reads module state directly
	function automatic logic [32:0] reg_word(input logic [AW-1:0] a);
		logic [31:0] w;
		logic        hit;
		w   = 32'h0;
		hit = 1'b1;
		if (a[`LEE_COEF_BIT] && a[AW-1:`LEE_COEF_BIT+1] == '0)
			w = 32'(signed'(coef_q[a[7]][a[6:2]]));
		else
			case (a)
				`LEE_A_CTRL:  w = 32'(ctrl_q);
				`LEE_A_CORE:  w = 32'(core_q);
				`LEE_A_SLOPE: w = 32'(gain_slope_q);
				`LEE_A_GAIN:  w = 32'(gain_q);
				`LEE_A_OUTSZ: w = {4'h0, oh_q, 4'h0, ow_q};
				`LEE_A_INSZ:  w = {4'h0, ih_q, 4'h0, iw_q};
				`LEE_A_RSZ:   w = {5'h00, vrsz_q, 5'h00, hrsz_q};
				`LEE_A_PHASE: w = {13'h0000, spv_q, 13'h0000, sph_q};
				`LEE_A_STAT:  w = 32'(stat_q);
				`LEE_A_LINE:  w = 32'(line_len_q);
				default:      hit = 1'b0;
			endcase
		reg_word = {hit, w};
	endfunction

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic [AW-1:0] aw_addr_q;             // Held write address
	logic [31:0]   w_data_q;              // Held write data
	logic [3:0]    w_strb_q;              // Held byte enables
	logic          wr_go;                 // Both halves held, no response pending
	logic [32:0]   wr_old;                // Current word at the write address
	logic [31:0]   wr_val;                // Merged word after byte enables

	assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	// Process form, so the view follows register changes and not only the address
	always_comb wr_old = reg_word(aw_addr_q);
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wr_val[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : wr_old[b*8 +: 8];
		end
	end

	// Address and data are taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_addr_q     <= '0;
			w_data_q      <= 32'h0;
			w_strb_q      <= 4'h0;
		end else begin
			// Capture address
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			// Capture data
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Answer; unmapped addresses get SLVERR
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_old[32] ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register updates from software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q       <= '0;
			core_q       <= `LEE_R_CORE;
			gain_slope_q <= `LEE_R_SLOPE;
			gain_q       <= `LEE_R_GAIN;
			ow_q         <= `LEE_R_SIZE;
			oh_q         <= `LEE_R_SIZE;
			iw_q         <= `LEE_R_SIZE;
			ih_q         <= `LEE_R_SIZE;
			hrsz_q       <= `LEE_R_RSZ;
			vrsz_q       <= `LEE_R_RSZ;
			sph_q        <= 3'h0;
			spv_q        <= 3'h0;
		end else if (wr_go && wr_old[32] && !aw_addr_q[`LEE_COEF_BIT]) begin
			case (aw_addr_q)
				`LEE_A_CTRL:  ctrl_q       <= lee_ctrl_t'(wr_val[2:0]);
				`LEE_A_CORE:  core_q       <= wr_val[7:0];
				`LEE_A_SLOPE: gain_slope_q <= wr_val[3:0];
				`LEE_A_GAIN:  gain_q       <= wr_val[7:0];
				`LEE_A_OUTSZ: begin
					ow_q <= wr_val[11:0];
					oh_q <= wr_val[`LEE_F_VLO +: 12];
				end
				`LEE_A_INSZ: begin
					iw_q <= wr_val[11:0];
					ih_q <= wr_val[`LEE_F_VLO +: 12];
				end
				`LEE_A_RSZ: begin
					hrsz_q <= lee_rsz(wr_val[10:0]);
					vrsz_q <= lee_rsz(wr_val[`LEE_F_VLO +: 11]);
				end
				`LEE_A_PHASE: begin
					sph_q <= wr_val[2:0];
					spv_q <= wr_val[`LEE_F_VLO +: 3];
				end
				default: ;
			endcase
		end
	end

	// Coefficient banks; no reset, software loads them before use
	always_ff @(posedge aclk) begin
		// 32 entries per direction, 10-bit signed
		if (wr_go && wr_old[32] && aw_addr_q[`LEE_COEF_BIT])
			coef_q[aw_addr_q[7]][aw_addr_q[6:2]] <= wr_val[9:0];
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic [32:0] rd_word;                 // Word at the read address
	// Process form: a repeated read of one address must still see fresh status
	always_comb rd_word = reg_word(s_axi_araddr);

	// One read at a time, data one edge after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word[31:0];
			s_axi_rresp   <= rd_word[32] ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Status: sizing checks and phase mode
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= 6'h00;
		end else begin
			stat_q[0] <= ow_q > (ctrl_q.v7 ? `LEE_MAXW_V7 : `LEE_MAXW_V4);
			stat_q[1] <= iw_q == lee_size(ctrl_q.v7, 1'b0, sph_q, ow_q, hrsz_q);
			stat_q[2] <= ih_q == lee_size(ctrl_q.v7, 1'b1, spv_q, oh_q, vrsz_q);
			stat_q[3] <= hang_q;
			stat_q[4] <= hrsz_q > `LEE_RSZ_4PH;
			stat_q[5] <= vrsz_q > `LEE_RSZ_4PH;
		end
	end

	// ----------------------------------------
	// Input delay line and line tracking
	// ----------------------------------------
	lee_pix_t    tap_q [5];               // tap_q[0] newest, tap_q[2] centre
	logic        s1_valid_q;              // Delay line advanced last edge
	logic [11:0] idx_q;                   // Index of tap_q[0] within its line
	logic [11:0] cnt_q;                   // Samples seen in current line
	logic        line_enh_q;              // Enable latched at line start
	logic        line_five_q;             // Kernel latched at line start

	// Shift in samples; enable and kernel changes only take effect at a line start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 5; i++)
				tap_q[i] <= '0;
			s1_valid_q  <= 1'b0;
			idx_q       <= 12'h000;
			cnt_q       <= 12'h000;
			line_enh_q  <= 1'b0;
			line_five_q <= 1'b0;
			line_len_q  <= 12'h000;
		end else begin
			s1_valid_q <= in_valid;
			if (in_valid) begin
				tap_q[0] <= in_pix;
				for (int i = 1; i < 5; i++)
					tap_q[i] <= tap_q[i-1];
				idx_q <= in_pix.sol ? 12'h000 : cnt_q;
				cnt_q <= in_pix.sol ? 12'h001 : cnt_q + 12'h001;
				if (in_pix.sol) begin
					line_enh_q  <= ctrl_q.en;
					line_five_q <= ctrl_q.five;
				end
				if (in_pix.eol)
					line_len_q <= in_pix.sol ? 12'h001 : cnt_q + 12'h001;
			end
		end
	end

	// Size fault: only a subsystem reset clears it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hang_q <= 1'b0;
		// enhanced lines carry four extra samples
		else if (s1_valid_q && tap_q[0].eol &&
			idx_q + 12'h001 != (line_enh_q ? ow_q + `LEE_TRIM : ow_q))
			hang_q <= 1'b1;
	end

	// ----------------------------------------
	// Enhancement arithmetic on the centre sample
	// ----------------------------------------
	logic signed [11:0] hp4_c;            // Detail times four
	logic signed [10:0] hp_c;             // Detail before clamp
	logic signed [8:0]  hpc_c;            // Clamped detail
	logic signed [9:0]  cored_c;          // Magnitude minus coring threshold
	logic signed [14:0] gprod_c;          // Cored value times slope
	logic [7:0]         gain_c;           // Clamped gain
	logic signed [16:0] det_c;            // Detail times gain
	logic signed [12:0] dsh_c;            // Rounded and shifted detail
	logic signed [13:0] ysum_c;           // Luma plus detail
	logic [7:0]         yenh_c;           // Enhanced luma

	always_comb begin
		if (line_five_q)
			hp4_c = 12'sd6 * $signed({4'h0, tap_q[2].luma})
				- 12'sd2 * ($signed({4'h0, tap_q[1].luma}) + $signed({4'h0, tap_q[3].luma}))
				- ($signed({4'h0, tap_q[0].luma}) + $signed({4'h0, tap_q[4].luma}));
		else
			hp4_c = 12'sd4 * $signed({4'h0, tap_q[2].luma})
				- 12'sd2 * ($signed({4'h0, tap_q[1].luma}) + $signed({4'h0, tap_q[3].luma}));
		hp_c = 11'(hp4_c >>> 2);
		if (hp_c > 11'(`LEE_HPF_MAX))
			hpc_c = `LEE_HPF_MAX;
		else if (hp_c < 11'(`LEE_HPF_MIN))
			hpc_c = `LEE_HPF_MIN;
		else
			hpc_c = 9'(hp_c);
		cored_c = (hpc_c < 0 ? -10'(hpc_c) : 10'(hpc_c)) - $signed({2'h0, core_q});
		gprod_c = 15'(cored_c) * $signed({11'h000, gain_slope_q});
		if (gprod_c < 0)
			gain_c = 8'h00;
		else if (gprod_c > $signed({7'h00, gain_q}))
			gain_c = gain_q;
		else
			gain_c = 8'(gprod_c);
		det_c  = 17'(hpc_c) * $signed({9'h000, gain_c});
		dsh_c  = 13'((det_c + `LEE_ROUND) >>> `LEE_SHIFT);
		ysum_c = $signed({6'h00, tap_q[2].luma}) + 14'(dsh_c);
		if (ysum_c < 0)
			yenh_c = 8'h00;
		else if (ysum_c > $signed({6'h00, `LEE_Y_MAX}))
			yenh_c = `LEE_Y_MAX;
		else
			yenh_c = 8'(ysum_c);
	end

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	// Trimmed lines drop the outer pairs; a hung block forwards nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_pix   <= '0;
		end else if (line_enh_q) begin
			out_valid <= s1_valid_q && !hang_q && idx_q >= `LEE_FIRST_IDX;
			// enhanced luma, chroma kept with its sample
			out_pix   <= '{luma: yenh_c, chroma: tap_q[2].chroma,
				sol: idx_q == `LEE_FIRST_IDX, eol: tap_q[0].eol};
		end else begin
			out_valid <= s1_valid_q && !hang_q;
			out_pix   <= tap_q[0];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_trim;
		s1_valid_q && line_enh_q && idx_q < `LEE_FIRST_IDX |=> !out_valid;
	endproperty
	a_trim: assert property (p_trim) else $error("trimmed sample forwarded");

	property p_clamp_hp;
		hpc_c >= `LEE_HPF_MIN && hpc_c <= `LEE_HPF_MAX && (hp_c > 11'sd255 -> hpc_c == 9'sd255);
	endproperty
	a_clamp_hp: assert property (p_clamp_hp) else $error("detail clamp wrong");

	property p_gain;
		gain_c <= gain_q && (gprod_c <= 0 -> gain_c == 8'h00);
	endproperty
	a_gain: assert property (p_gain) else $error("gain out of range");

	property p_enh_out;
		s1_valid_q && line_enh_q && !hang_q && idx_q >= `LEE_FIRST_IDX
			|=> out_valid && out_pix.luma == $past(yenh_c) && out_pix.chroma == $past(tap_q[2].chroma);
	endproperty
	a_enh_out: assert property (p_enh_out) else $error("enhanced sample wrong");

	property p_bypass;
		s1_valid_q && !line_enh_q && !hang_q |=> out_valid && out_pix == $past(tap_q[0]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered sample");

	property p_phase;
		$changed(hrsz_q) |-> ##2 stat_q[4] == (hrsz_q > `LEE_RSZ_4PH);
	endproperty
	a_phase: assert property (p_phase) else $error("phase mode wrong");

	property p_rsz;
		hrsz_q >= `LEE_RSZ_MIN && hrsz_q <= `LEE_RSZ_MAX && vrsz_q >= `LEE_RSZ_MIN && vrsz_q <= `LEE_RSZ_MAX;
	endproperty
	a_rsz: assert property (p_rsz) else $error("factor out of span");

	property p_hang;
		hang_q |=> hang_q [*4] ##1 !out_valid;
	endproperty
	a_hang: assert property (p_hang) else $error("hang released early");

	property p_limit;
		!$changed(ow_q) && !$changed(ctrl_q)
			|-> stat_q[0] == (ow_q > (ctrl_q.v7 ? `LEE_MAXW_V7 : `LEE_MAXW_V4));
	endproperty
	a_limit: assert property (p_limit) else $error("width limit flag wrong");
endmodule

/* File: tb/lee_feeder.sv */
// Model of the horizontal resize stage that feeds one line of samples
`timescale 1ns/1ps
module lee_feeder
	import lee_pkg::*;
(
	// Clock and line request
	input  wire logic        aclk,
	input  wire logic        go,
	input  wire logic [11:0] len,
	// Samples toward the enhancer
	output logic             in_valid,
	output lee_pix_t         in_pix,
	output logic             busy
);
	logic [11:0] cnt_q; // Index of the next sample
	initial begin
		in_valid = 1'b0;
		in_pix = '0;
		busy = 1'b0;
		cnt_q = 12'h000;
	end
	// line length as asked
	// The bench asks for output width plus four when enhancing, except the 10-sample hang line, and keeps widths legal
	always @(posedge aclk) begin
		if (busy) begin
			in_valid <= 1'b1;
			in_pix <= '{((cnt_q % 3) == 0) ? 8'hFF : 8'h10, cnt_q[7:0], cnt_q == 12'h000,
				cnt_q == len - 12'h001};
			cnt_q <= cnt_q + 12'h001;
			busy <= (cnt_q != len - 12'h001);
		end else begin
			// Idle lines show the inverse, so a stale copy is never mistaken for data
			in_valid <= 1'b0;
			in_pix <= ~in_pix;
			cnt_q <= 12'h000;
			busy <= go;
		end
	end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the luma edge enhancer
`timescale 1ns/1ps
`include "lee_defs.svh"
module tb;
	import lee_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        go = 1'b0;
	logic [11:0] len = 12'h000;
	logic        awready, wready, bvalid, arready, rvalid, in_valid, out_valid, busy;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	lee_pix_t    in_pix, out_pix;
	lee_pix_t    got[$]; // Forwarded samples of the current line
	int          miscompares = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #4 aclk = ~aclk;
	lee_enhance dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .in_valid(in_valid),
		.in_pix(in_pix), .out_valid(out_valid), .out_pix(out_pix));
	lee_feeder feed_u (.aclk(aclk), .go(go), .len(len), .in_valid(in_valid), .in_pix(in_pix), .busy(busy));
	// Output pulses are looked at mid-cycle, clear of the launching edge
	always @(negedge aclk) begin
		if (out_valid === 1'b1)
			got.push_back(out_pix);
	end
	// Watchdog: a hang of the bench counts as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic at, wt, ah, wh, bh;
		at = 1'b0;
		wt = 1'b0;
		bh = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(at && wt)) begin
			@(negedge aclk);
			ah = awvalid && awready === 1'b1;
			wh = wvalid && wready === 1'b1;
			@(posedge aclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			at = at || ah;
			wt = wt || wh;
		end
		while (!bh) begin
			@(negedge aclk);
			bh = bvalid === 1'b1;
			r = bresp;
			@(posedge aclk);
		end
	endtask
	task automatic wrs(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h;
		h = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!h) begin
			@(negedge aclk);
			h = arvalid && arready === 1'b1;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		h = 1'b0;
		while (!h) begin
			@(negedge aclk);
			h = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
	endtask
	// Masked register read, judged at the caller's line
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), d & m, e);
	endtask
	function automatic int yv(input int i);
		return ((i % 3) == 0) ? 255 : 16;
	endfunction
	// Reference enhancement of centre sample j, floor on the quarter kernels
	function automatic logic [7:0] enh(input logic five, input int j, input int core, input int slope,
		input int gmax);
		int hp, g, y;
		hp = five ? (-yv(j-2) - 2*yv(j-1) + 6*yv(j) - 2*yv(j+1) - yv(j+2)) >>> 2
			: (-2*yv(j-1) + 4*yv(j) - 2*yv(j+1)) >>> 2;
		hp = (hp > 255) ? 255 : (hp < -256) ? -256 : hp;
		g = ((hp < 0) ? -hp : hp) - core;
		g = g * slope;
		g = (g < 0) ? 0 : (g > gmax) ? gmax : g;
		y = yv(j) + ((hp * g + 8) >>> 4);
		return (y > 255) ? 8'hFF : (y < 0) ? 8'h00 : 8'(y);
	endfunction
	task automatic run_line(input int n);
		got.delete();
		len <= 12'(n);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (3) @(negedge aclk);
		while (busy === 1'b1) @(negedge aclk);
		repeat (8) @(negedge aclk);
		@(posedge aclk);
	endtask
	task automatic cmp_line(input logic en, input logic five, input int core, input int slope, input int gmax,
		input int n);
		int k, m;
		k = en ? 2 : 0;
		m = en ? n - 4 : n;
		chk("count", got.size(), m); // trimmed length
		for (int i = 0; i < got.size() && i < m; i++) begin
			chk("luma", got[i].luma, en ? enh(five, i + k, core, slope, gmax) : yv(i)); // luma
			chk("chroma", got[i].chroma, 8'(i + k)); // chroma kept
			chk("sol", got[i].sol, i == 0); // first kept sample
			chk("eol", got[i].eol, i == m - 1); // last kept sample
		end
	endtask
	task automatic s_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rchk(`LEE_A_CORE, 32'hFF, 32'h0); // coring reset
		rchk(`LEE_A_SLOPE, 32'hF, 32'h1); // slope reset
		rchk(`LEE_A_GAIN, 32'hFF, 32'h10); // ceiling reset
		rchk(`LEE_A_RSZ, 32'h07FF07FF, 32'h01000100); // unity factors
		rd(12'h040, d, r);
		chk("rresp", r, 2'b10); // refused address
	endtask
	task automatic s_size();
		wrs(`LEE_A_OUTSZ, 32'h00040008);
		wrs(`LEE_A_INSZ, 32'h0007000E);
		rchk(`LEE_A_STAT, 32'h6, 32'h6); // sizes match
		wrs(`LEE_A_OUTSZ, 32'h00040500);
		rchk(`LEE_A_STAT, 32'h1, 32'h0); // width at limit
		wrs(`LEE_A_OUTSZ, 32'h00040501);
		rchk(`LEE_A_STAT, 32'h1, 32'h1); // width over limit
		wrs(`LEE_A_CTRL, 32'h4);
		wrs(`LEE_A_OUTSZ, 32'h00040281);
		rchk(`LEE_A_STAT, 32'h1, 32'h1); // seven-tap limit
		wrs(`LEE_A_OUTSZ, 32'h00040008);
		wrs(`LEE_A_PHASE, 32'h00000004);
		wrs(`LEE_A_INSZ, 32'h000A000F);
		rchk(`LEE_A_STAT, 32'h6, 32'h6); // seven-tap sizes match
		wrs(`LEE_A_PHASE, 32'h00000000);
		wrs(`LEE_A_CTRL, 32'h0);
	endtask
	task automatic s_rsz();
		logic [1:0] r;
		wrs(`LEE_A_RSZ, 32'h001007FF);
		rchk(`LEE_A_RSZ, 32'h07FF07FF, 32'h00400400); // factors clamped
		rchk(`LEE_A_STAT, 32'h30, 32'h10); // phase count
		wrs(`LEE_A_RSZ, 32'h02010200);
		rchk(`LEE_A_STAT, 32'h30, 32'h20); // boundary of phases
		wr(12'h040, 32'h0, r);
		chk("bresp", r, 2'b10); // refused write
		rchk(`LEE_A_RSZ, 32'h07FF07FF, 32'h02010200); // no side effect
		wrs(12'h100, 32'h000003FF);
		wrs(12'h1FC, 32'h00000100);
		rchk(12'h100, 32'hFFFFFFFF, 32'hFFFFFFFF); // horizontal entry sign-extended
		rchk(12'h1FC, 32'hFFFFFFFF, 32'h00000100); // last vertical entry
	endtask
	task automatic s_bypass();
		wrs(`LEE_A_CTRL, 32'h0);
		run_line(8);
		cmp_line(1'b0, 1'b0, 0, 1, 16, 8); // full line untouched
		rchk(`LEE_A_LINE, 32'hFFF, 32'h8); // full line counted
	endtask
	task automatic s_enh3();
		wrs(`LEE_A_CTRL, 32'h1);
		run_line(12);
		cmp_line(1'b1, 1'b0, 0, 1, 16, 12); // three-tap line
	endtask
	task automatic s_enh5();
		wrs(`LEE_A_CORE, 32'h4);
		wrs(`LEE_A_SLOPE, 32'h2);
		wrs(`LEE_A_GAIN, 32'h20);
		wrs(`LEE_A_CTRL, 32'h3);
		run_line(12);
		cmp_line(1'b1, 1'b1, 4, 2, 32, 12); // five-tap line
	endtask
	task automatic s_hang();
		wrs(`LEE_A_CTRL, 32'h1);
		run_line(10);
		rchk(`LEE_A_STAT, 32'h8, 32'h8); // wrong length hangs
		run_line(12);
		chk("count", got.size(), 0); // output stalled
		do_reset();
		rchk(`LEE_A_STAT, 32'h8, 32'h0); // reset recovers
		wrs(`LEE_A_CTRL, 32'h1);
		wrs(`LEE_A_OUTSZ, 32'h00040008);
		run_line(12);
		cmp_line(1'b1, 1'b0, 0, 1, 16, 12); // defaults after reset
	endtask
	initial begin
		do_reset();
		s_regs();
		s_size();
		s_rsz();
		s_bypass();
		s_enh3();
		s_enh5();
		s_hang();
		wrap_up();
	end
endmodule
